// file: logic/gpb_pkg.sv
// Constants, register map and carrier types of the pin block.
// How it works
// - Pins 5, 7, 9: input, edge-irq, output.
// - Pins 8, 10, 11: pin or card supply.
// - Pins 8, 10, 11 pin mode: full choices.
// - Pins 15 to 12: input or output only.
// - Strap pull-up on while chip reset low.
// - Pull-up released some cycles after release.
// - Strap level captured at chip reset rise.
// - Captured strap readable in input register.
// - After reset pin 6 is pin or serial receive.
// - Low strap selects external code memory.
// - High strap selects internal code memory.
// - Code memory select active except in chip reset or standby.
package gpb_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_PIN_IN = 8'h00;
  localparam logic [AXI_AW-1:0] REG_DIR = 8'h04;
  localparam logic [AXI_AW-1:0] REG_OUT = 8'h08;
  localparam logic [AXI_AW-1:0] REG_IRQ_MODE = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_EDGE = 8'h10;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h14;
  localparam logic [AXI_AW-1:0] REG_MASK = 8'h18;
  localparam logic [AXI_AW-1:0] REG_CARD = 8'h1c;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h20;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int PIN_W = 16;
  localparam logic [15:0] GP_MASK = 16'hffe0;
  localparam logic [15:0] IRQ_CAP_MASK = 16'h0fa0;
  localparam logic [15:0] CARD_MASK = 16'h0d00;
  localparam int PIN_STRAP = 6;
  localparam int IN_STRAP_BIT = 0;
  localparam int IN_TEST_LSB = 1;
  localparam int CTRL_STANDBY = 0;
  localparam int CTRL_RXD = 1;
  localparam logic [1:0] CTRL_MASK = 2'h3;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // ----------------------------------------
  // Timing and bus answers
  // ----------------------------------------
  localparam logic [2:0] PULLUP_HOLD_CYC = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [AXI_AW-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } gpb_wreq_t;

  typedef enum logic [2:0] {
    BOOT_HOLD = 3'b001,
    BOOT_RELEASE = 3'b010,
    BOOT_RUN = 3'b100
  } gpb_boot_t;

endpackage

// file: logic/gpb_edge_cell.sv
// One synchronised edge detector for an interrupt-capable pin.
`timescale 1ns/1ps
module gpb_edge_cell
  import gpb_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic rst, // Synchronous reset.
  input wire logic pin, // Pin level.
  input wire logic rise_sel, // 1 rising, 0 falling.
  input wire logic arm, // Edge interrupt mode.
  output logic level, // Synchronised level.
  output logic event_hit // One-cycle edge pulse.
);

  logic sync1;
  logic sync2;
  logic prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign level = sync2;
  assign event_hit = arm & (rise_sel ? (sync2 & ~prev) : (~sync2 & prev));

endmodule

// file: logic/gpb_axi_slave.sv
// AXI4-Lite slave front end that turns bus traffic into strobes.
`timescale 1ns/1ps
module gpb_axi_slave
  import gpb_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic rst, // Synchronous reset.
  input wire logic [AXI_AW-1:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [AXI_AW-1:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output logic wr_en, // Write strobe.
  output gpb_wreq_t wreq, // Write request.
  input wire logic wr_ok, // Write address mapped.
  output logic rd_en, // Read strobe.
  input wire logic rd_ok, // Read address mapped.
  input wire logic [31:0] rd_data // Read value.
);

  logic aw_hold;
  logic w_hold;
  gpb_wreq_t wq;
  logic aw_go;
  logic w_go;

  assign awready = ~aw_hold & ~bvalid;
  assign wready = ~w_hold & ~bvalid;
  assign arready = ~rvalid;
  assign aw_go = awvalid & awready;
  assign w_go = wvalid & wready;
  assign rd_en = arvalid & arready;
  assign wr_en = (aw_hold | aw_go) & (w_hold | w_go);
  assign wreq.addr = aw_hold ? wq.addr : awaddr;
  assign wreq.data = w_hold ? wq.data : wdata;
  assign wreq.strb = w_hold ? wq.strb : wstrb;

  // Address and data may arrive in either order; each is parked until its partner shows up.
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      wq <= '0;
    end else if (wr_en) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
    end else begin
      if (aw_go) begin
        aw_hold <= 1'b1;
        wq.addr <= awaddr;
      end
      if (w_go) begin
        w_hold <= 1'b1;
        wq.data <= wdata;
        wq.strb <= wstrb;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rd_en) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// file: logic/gpb_top.sv
// General purpose pin block with boot strap capture and register bank.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module gpb_top
  import gpb_pkg::*;
(
  input wire logic MCLK, // Core clock, 20 MHz.
  input wire logic RST, // Synchronous reset, active high.
  input wire logic CHIP_RESET_N, // Chip reset pin, active low.
  input wire logic [1:0] FACTORY_TEST_N, // Factory test inputs.
  input wire logic [PIN_W-1:0] PIN_IN, // Pin levels.
  output logic [PIN_W-1:0] PIN_OUT, // Pin output levels.
  output logic [PIN_W-1:0] PIN_OE, // Pin output enables.
  output logic STRAP_PULLUP_EN, // Weak pull-up on pin 6.
  output logic BOOT_EXTERNAL, // Fetch code from external bus.
  output logic CODE_MEM_SELECT_N, // Code memory select, active low.
  output logic SERIAL_RX_DATA, // Serial receive data from pin 6.
  output logic IRQ, // Level interrupt.
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR, // Write address.
  input wire logic S_AXI_AWVALID, // Write address valid.
  output logic S_AXI_AWREADY, // Write address ready.
  input wire logic [31:0] S_AXI_WDATA, // Write data.
  input wire logic [3:0] S_AXI_WSTRB, // Byte strobes.
  input wire logic S_AXI_WVALID, // Write data valid.
  output logic S_AXI_WREADY, // Write data ready.
  output logic [1:0] S_AXI_BRESP, // Write response.
  output logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR, // Read address.
  input wire logic S_AXI_ARVALID, // Read address valid.
  output logic S_AXI_ARREADY, // Read address ready.
  output logic [31:0] S_AXI_RDATA, // Read data.
  output logic [1:0] S_AXI_RRESP, // Read response.
  output logic S_AXI_RVALID, // Read data valid.
  input wire logic S_AXI_RREADY // Read data ready.
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic addr_hit(input logic [AXI_AW-1:0] a);
    addr_hit = (a == REG_PIN_IN) || (a == REG_DIR) || (a == REG_OUT) ||
      (a == REG_IRQ_MODE) || (a == REG_EDGE) || (a == REG_STATUS) ||
      (a == REG_MASK) || (a == REG_CARD) || (a == REG_CTRL);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  logic wr_en;
  gpb_wreq_t wreq;
  logic rd_en;
  logic [31:0] rd_data;

  gpb_axi_slave u_bus (
    .clk(MCLK),
    .rst(RST),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wreq(wreq),
    .wr_ok(addr_hit(wreq.addr)),
    .rd_en(rd_en),
    .rd_ok(addr_hit(S_AXI_ARADDR)),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [15:0] dir;
  logic [15:0] out_val;
  logic [15:0] irq_mode;
  logic [15:0] edge_rise;
  logic [15:0] status;
  logic [15:0] mask;
  logic [15:0] card_sel;
  logic [1:0] ctrl;

  function automatic logic wr_at(input logic [AXI_AW-1:0] a);
    wr_at = wr_en && (wreq.addr == a);
  endfunction

  always_ff @(posedge MCLK) begin
    if (RST) begin
      dir <= ZERO16;
      out_val <= ZERO16;
      irq_mode <= ZERO16;
      edge_rise <= ZERO16;
      mask <= ZERO16;
      ctrl <= '0;
    end else begin
      if (wr_at(REG_DIR))
        dir <= merge16(dir, wreq.data, wreq.strb) & GP_MASK;
      if (wr_at(REG_OUT))
        out_val <= merge16(out_val, wreq.data, wreq.strb) & GP_MASK;
      if (wr_at(REG_IRQ_MODE))
        irq_mode <= merge16(irq_mode, wreq.data, wreq.strb) & IRQ_CAP_MASK;
      if (wr_at(REG_EDGE))
        edge_rise <= merge16(edge_rise, wreq.data, wreq.strb) & IRQ_CAP_MASK;
      if (wr_at(REG_MASK))
        mask <= merge16(mask, wreq.data, wreq.strb) & IRQ_CAP_MASK;
      if (wr_at(REG_CTRL) && wreq.strb[0])
        ctrl <= wreq.data[1:0] & CTRL_MASK;
    end
  end

  // Card supply selection is only honoured on the three power-capable pins.
  always_ff @(posedge MCLK) begin
    if (RST)
      card_sel <= ZERO16;
    else if (wr_at(REG_CARD))
      card_sel <= merge16(card_sel, wreq.data, wreq.strb) & CARD_MASK;
  end

  // ----------------------------------------
  // Boot strap and chip reset sequencing
  // ----------------------------------------
  gpb_boot_t boot_state;
  logic [2:0] hold_cnt;
  logic strap;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      boot_state <= BOOT_HOLD;
      hold_cnt <= '0;
    end else begin
      unique case (boot_state)
        BOOT_HOLD: begin
          hold_cnt <= '0;
          if (CHIP_RESET_N)
            boot_state <= BOOT_RELEASE;
        end
        BOOT_RELEASE: begin
          hold_cnt <= hold_cnt + 3'h1;
          if (!CHIP_RESET_N)
            boot_state <= BOOT_HOLD;
          else if (hold_cnt == PULLUP_HOLD_CYC - 3'h1)
            boot_state <= BOOT_RUN;
        end
        BOOT_RUN: begin
          if (!CHIP_RESET_N)
            boot_state <= BOOT_HOLD;
        end
        default: boot_state <= BOOT_HOLD;
      endcase
    end
  end

  // The pin is sampled in the cycle the chip reset is first seen high, while the pull-up still acts.
  always_ff @(posedge MCLK) begin
    if (RST)
      strap <= 1'b1;
    else if (boot_state == BOOT_HOLD && CHIP_RESET_N)
      strap <= PIN_IN[PIN_STRAP];
  end

  assign STRAP_PULLUP_EN = (boot_state != BOOT_RUN);
  assign BOOT_EXTERNAL = ~strap;

  // Held high during chip reset so no code fetch is started before the strap is known.
  always_ff @(posedge MCLK) begin
    if (RST)
      CODE_MEM_SELECT_N <= 1'b1;
    else
      CODE_MEM_SELECT_N <= ~CHIP_RESET_N | ctrl[CTRL_STANDBY];
  end

  // ----------------------------------------
  // Pin inputs and edge events
  // ----------------------------------------
  logic [15:0] level;
  logic [15:0] ev;

  for (genvar i = 0; i < PIN_W; i++) begin : g_pin
    if (IRQ_CAP_MASK[i]) begin : g_irq
      gpb_edge_cell u_cell (
        .clk(MCLK),
        .rst(RST),
        .pin(PIN_IN[i]),
        .rise_sel(edge_rise[i]),
        .arm(irq_mode[i] & ~card_sel[i]),
        .level(level[i]),
        .event_hit(ev[i])
      );
    end else begin : g_plain
      assign level[i] = PIN_IN[i] & GP_MASK[i];
      assign ev[i] = 1'b0;
    end
  end

  // A read of the status register clears it, but an edge in that same cycle survives.
  always_ff @(posedge MCLK) begin
    if (RST)
      status <= ZERO16;
    else
      status <= ((rd_en && S_AXI_ARADDR == REG_STATUS) ? ZERO16 : status) | ev;
  end

  assign IRQ = |(status & mask);

  always_ff @(posedge MCLK) begin
    if (RST)
      SERIAL_RX_DATA <= 1'b1;
    else
      SERIAL_RX_DATA <= (boot_state == BOOT_RUN && ctrl[CTRL_RXD]) ? PIN_IN[PIN_STRAP] : 1'b1;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [15:0] in_word;

  always_comb begin
    in_word = level & GP_MASK;
    in_word[IN_STRAP_BIT] = strap;
    in_word[IN_TEST_LSB +: 2] = FACTORY_TEST_N;
    unique case (S_AXI_ARADDR)
      REG_PIN_IN: rd_data = {16'h0000, in_word};
      REG_DIR: rd_data = {16'h0000, dir};
      REG_OUT: rd_data = {16'h0000, out_val};
      REG_IRQ_MODE: rd_data = {16'h0000, irq_mode};
      REG_EDGE: rd_data = {16'h0000, edge_rise};
      REG_STATUS: rd_data = {16'h0000, status};
      REG_MASK: rd_data = {16'h0000, mask};
      REG_CARD: rd_data = {16'h0000, card_sel};
      REG_CTRL: rd_data = {30'h0, ctrl};
      default: rd_data = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  logic [15:0] next_oe;
  logic [15:0] next_out;

  // Edge interrupt mode forces a pin to input unless card supply mode is set; card supply mode forces it to drive.
  always_comb begin
    next_oe = dir & ~irq_mode & GP_MASK;
    next_oe = next_oe | card_sel;
    if (boot_state != BOOT_RUN || ctrl[CTRL_RXD])
      next_oe[PIN_STRAP] = 1'b0;
    next_out = out_val & GP_MASK;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      PIN_OE <= ZERO16;
      PIN_OUT <= ZERO16;
    end else begin
      PIN_OE <= next_oe;
      PIN_OUT <= next_out;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  chk_pullup_held: assert property (!CHIP_RESET_N |=> STRAP_PULLUP_EN)
    else $error("strap pull-up off during chip reset");

  chk_pullup_late: assert property (($rose(CHIP_RESET_N) ##1 CHIP_RESET_N[*4]) |-> STRAP_PULLUP_EN)
    else $error("strap pull-up released too early");

  chk_pullup_off: assert property (($rose(CHIP_RESET_N) ##1 CHIP_RESET_N[*5]) |-> !STRAP_PULLUP_EN)
    else $error("strap pull-up not released");

  chk_strap_latch: assert property ((boot_state == BOOT_HOLD && CHIP_RESET_N)
    |=> BOOT_EXTERNAL == !$past(PIN_IN[PIN_STRAP]))
    else $error("strap level not captured");

  chk_strap_hold: assert property (boot_state == BOOT_RUN |=> $stable(BOOT_EXTERNAL))
    else $error("boot source changed after release");

  chk_strap_read: assert property ((rd_en && S_AXI_ARADDR == REG_PIN_IN)
    |=> S_AXI_RDATA[IN_STRAP_BIT] == !BOOT_EXTERNAL)
    else $error("strap bit read back wrong");

  chk_mem_select: assert property ((CHIP_RESET_N && !ctrl[CTRL_STANDBY]) |=> !CODE_MEM_SELECT_N)
    else $error("code memory select not active");

  chk_irq_set: assert property ((|ev) |=> (status & $past(ev)) == $past(ev))
    else $error("edge did not set pending");

  chk_irq_none: assert property ((status & ~IRQ_CAP_MASK) == ZERO16)
    else $error("pending set on pin without interrupt");

  chk_card_drive: assert property (card_sel[8] |=> PIN_OE[8] && PIN_OUT[8] == $past(out_val[8]))
    else $error("card supply pin not driven");

  chk_card_reset: assert property ($past(RST) |-> card_sel == ZERO16)
    else $error("card select not cleared by reset");

  chk_strap_input: assert property ((boot_state != BOOT_RUN) |=> !PIN_OE[PIN_STRAP])
    else $error("strap pin driven before release");

  chk_irq_input: assert property ((irq_mode[5] || irq_mode[7]) |=> !(PIN_OE[5] && irq_mode[5]))
    else $error("interrupt pin driven");

  cov_boot_ext: cover property ($rose(CHIP_RESET_N) && !PIN_IN[PIN_STRAP]);
  cov_irq_fire: cover property ($rose(IRQ));
  cov_status_clear: cover property (rd_en && S_AXI_ARADDR == REG_STATUS && (|status));
  cov_card_on: cover property ($rose(PIN_OE[11]) && card_sel[11]);

endmodule

// file: sim/gpb_board.sv
// Board model: buttons, LEDs, card sockets and the boot strap resistor.
`timescale 1ns/1ps
module gpb_board
  import gpb_pkg::*;
(
  input wire logic clk, // Core clock, paces the floating pattern.
  input wire logic [PIN_W-1:0] oe, // Device output enables.
  input wire logic [PIN_W-1:0] out, // Device output levels.
  input wire logic pull_en, // Device weak pull-up on pin 6.
  input wire logic strap_low, // Weak pull-down fitted on pin 6.
  input wire logic [PIN_W-1:0] ext_drv, // Board drivers enabled.
  input wire logic [PIN_W-1:0] ext_lvl, // Board driver levels.
  output logic [PIN_W-1:0] pin // Resolved pin levels.
);
  logic flip = 1'b0;

  // A pin that nobody drives keeps changing, so a stale level is never read as valid.
  always @(posedge clk) flip <= ~flip;

  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (oe[i]) pin[i] = out[i];
      else if (ext_drv[i]) pin[i] = ext_lvl[i];
      else pin[i] = flip ^ i[0];
    end
    if (!oe[PIN_STRAP] && !ext_drv[PIN_STRAP]) begin
      if (strap_low) pin[PIN_STRAP] = 1'b0;
      else if (pull_en) pin[PIN_STRAP] = 1'b1;
    end
  end
endmodule

// file: sim/gpio_pins_with_boot_strap_tb.sv
// Self-checking bench for the general purpose pin block.
`timescale 1ns/1ps
module gpio_pins_with_boot_strap_tb
  import gpb_pkg::*;
;
  logic mclk, rst, chip_rst_n, strap_low, pull_en, boot_ext, cmem_n, rxd, irq;
  logic [1:0] test_n;
  logic [PIN_W-1:0] pin_in, pin_out, pin_oe, ext_drv, ext_lvl;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_fail, tests_run;

  gpb_top i_gpb_top (.MCLK(mclk), .RST(rst), .CHIP_RESET_N(chip_rst_n), .FACTORY_TEST_N(test_n),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .STRAP_PULLUP_EN(pull_en),
    .BOOT_EXTERNAL(boot_ext), .CODE_MEM_SELECT_N(cmem_n), .SERIAL_RX_DATA(rxd), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  gpb_board i_gpb_board (.clk(mclk), .oe(pin_oe), .out(pin_out), .pull_en(pull_en), .strap_low(strap_low),
    .ext_drv(ext_drv), .ext_lvl(ext_lvl), .pin(pin_in));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic give_up();
    n_fail++;
    $display("BAD %0t: wait ran out", $time);
    wrap_up();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask

  task automatic w(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, RESP_OKAY);
    // Pin drivers follow a register write by one cycle; let that edge pass before anyone looks.
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(r, RESP_OKAY);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_vals();
    logic [7:0] a [8] = '{REG_DIR, REG_OUT, REG_IRQ_MODE, REG_EDGE, REG_STATUS, REG_MASK, REG_CARD, REG_CTRL};
    foreach (a[i]) rchk(a[i], 32'h0);
    chk(pin_oe, 16'h0000);
    chk(irq, 1'b0);
  endtask

  task automatic boot(input logic lo);
    strap_low <= lo;
    ext_drv[PIN_STRAP] <= 1'b0;
    chip_rst_n <= 1'b0;
    repeat (24) @(posedge mclk);
    chk(pull_en, 1'b1);
    chk(cmem_n, 1'b1);
    chip_rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(pull_en, 1'b1);
    repeat (8) @(posedge mclk);
    chk(pull_en, 1'b0);
    chk(boot_ext, lo);
    chk(cmem_n, 1'b0);
    // Once the pull-up lets go a bare strap pin floats, so the board holds it low for the read.
    ext_drv[PIN_STRAP] <= 1'b1;
    rchk(REG_PIN_IN, {29'h0, test_n, ~lo});
  endtask

  task automatic outputs();
    w(REG_DIR, 16'hffff);
    w(REG_OUT, 16'ha5a0);
    chk(pin_oe, 16'hffe0);
    chk(pin_out, 16'ha5a0);
    repeat (4) @(posedge mclk);
    rchk(REG_PIN_IN, 32'ha5a6);
  endtask

  task automatic card();
    w(REG_CARD, 16'hffff);
    rchk(REG_CARD, 32'h0d00);
    w(REG_DIR, 16'h0000);
    chk(pin_oe, 16'h0d00);
    chk(pin_out & 16'h0d00, 16'h0500);
    w(REG_CARD, 16'h0000);
    chk(pin_oe, 16'h0000);
  endtask

  task automatic ctrl();
    w(REG_DIR, 16'h0040);
    w(REG_CTRL, 16'h0002);
    chk(pin_oe, 16'h0000);
    ext_drv[PIN_STRAP] <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(rxd, 1'b0);
    ext_lvl[PIN_STRAP] <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(rxd, 1'b1);
    ext_drv[PIN_STRAP] <= 1'b0;
    w(REG_CTRL, 16'h0000);
    chk(pin_oe, 16'h0040);
    w(REG_CTRL, 16'h0001);
    chk(cmem_n, 1'b1);
    w(REG_CTRL, 16'h0000);
    chk(cmem_n, 1'b0);
    w(REG_DIR, 16'h0000);
  endtask

  task automatic irqs();
    int p [6] = '{5, 7, 8, 9, 10, 11};
    logic [31:0] d;
    logic [1:0] r;
    int n;
    w(REG_IRQ_MODE, 16'hffff);
    rchk(REG_IRQ_MODE, 32'h0fa0);
    w(REG_DIR, 16'hffff);
    chk(pin_oe, 16'hf040);
    w(REG_DIR, 16'h0000);
    w(REG_EDGE, 16'h0fa0);
    w(REG_MASK, 16'h0fa0);
    rd(REG_STATUS, d, r);
    foreach (p[i]) begin
      ext_lvl[p[i]] <= 1'b1;
      for (n = 0; n < 12 && irq !== 1'b1; n++) @(posedge mclk);
      if (n == 12) give_up();
      rchk(REG_STATUS, 32'h1 << p[i]);
      chk(irq, 1'b0);
      ext_lvl[p[i]] <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(irq, 1'b0);
    end
    w(REG_EDGE, 16'h0000);
    w(REG_MASK, 16'h0000);
    ext_lvl[5] <= 1'b1;
    repeat (6) @(posedge mclk);
    ext_lvl[5] <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(irq, 1'b0);
    rchk(REG_STATUS, 32'h0020);
    w(REG_IRQ_MODE, 16'h0000);
  endtask

  task automatic unmapped();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h40, 16'h1234, r);
    chk(r, RESP_SLVERR);
    rd(8'h40, d, r);
    chk(r, RESP_SLVERR);
  endtask

  initial begin
    n_fail = 0;
    tests_run = 0;
    rst = 1'b1;
    chip_rst_n = 1'b0;
    test_n = 2'b11;
    strap_low = 1'b0;
    ext_drv = 16'hffa0;
    ext_lvl = 16'h0000;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    reset_vals();
    boot(1'b0);
    boot(1'b1);
    outputs();
    card();
    ctrl();
    irqs();
    unmapped();
    wrap_up();
  end
endmodule
